// ===== shared/gtp_pkg.sv
/*
 * Constants and types shared by the gated timer block: register indices,
 * field positions, reset values, source codes and the state record.
 * Assumes an 8-bit register port with a 3-bit register index.
 */
package gtp_pkg;

    // Register port widths.
    localparam int GTP_AW = 3;
    localparam int GTP_DW = 8;

    // Register indices on the register port.
    localparam logic [2:0] GTP_A_T1CTL = 3'h0;
    localparam logic [2:0] GTP_A_T1GATE = 3'h1;
    localparam logic [2:0] GTP_A_T1LO = 3'h2;
    localparam logic [2:0] GTP_A_T1HI = 3'h3;
    localparam logic [2:0] GTP_A_T2CNT = 3'h4;
    localparam logic [2:0] GTP_A_T2PER = 3'h5;
    localparam logic [2:0] GTP_A_T2CTL = 3'h6;
    localparam logic [2:0] GTP_A_FLAGS = 3'h7;

    // Timer1 control fields.
    localparam int GTP_T1_ON = 0;
    localparam int GTP_T1_NOSYNC = 2;
    localparam int GTP_T1_OSCEN = 3;
    localparam int GTP_T1_PS = 4;
    localparam int GTP_T1_CS = 6;

    // Timer1 gate control fields.
    localparam int GTP_G_SS = 0;
    localparam int GTP_G_VAL = 2;
    localparam int GTP_G_GO = 3;
    localparam int GTP_G_SPM = 4;
    localparam int GTP_G_TM = 5;
    localparam int GTP_G_POL = 6;
    localparam int GTP_G_EN = 7;

    // Timer2 control fields.
    localparam int GTP_T2_PS = 0;
    localparam int GTP_T2_ON = 2;
    localparam int GTP_T2_POST = 3;

    // Flag register fields.
    localparam int GTP_F_OVF = 0;
    localparam int GTP_F_T2 = 1;
    localparam int GTP_F_GATE = 7;

    // Reset values and writable masks.
    localparam logic [7:0] GTP_T1CTL_RST = 8'h00;
    localparam logic [7:0] GTP_T1GATE_RST = 8'h00;
    localparam logic [7:0] GTP_T2CTL_RST = 8'h00;
    localparam logic [15:0] GTP_T1CNT_RST = 16'h0000;
    localparam logic [7:0] GTP_T2CNT_RST = 8'h00;
    localparam logic [7:0] GTP_T2PER_RST = 8'hFF;
    localparam logic [7:0] GTP_T1CTL_MASK = 8'hFD;
    localparam logic [7:0] GTP_T1GATE_MASK = 8'hF3;
    localparam logic [7:0] GTP_T2CTL_MASK = 8'h7F;

    // Clock source and gate source codes.
    localparam logic [1:0] GTP_CS_QUARTER = 2'h0;
    localparam logic [1:0] GTP_CS_SYS = 2'h1;
    localparam logic [1:0] GTP_CS_EXT = 2'h2;
    localparam logic [1:0] GTP_CS_CAP = 2'h3;
    localparam logic [1:0] GTP_GS_PIN = 2'h0;
    localparam logic [1:0] GTP_GS_T0 = 2'h1;
    localparam logic [1:0] GTP_GS_T2 = 2'h2;
    localparam logic [1:0] GTP_GS_WDT = 2'h3;

    // Timer2 prescaler terminal counts for 1:1, 1:4 and 1:16.
    localparam logic [3:0] GTP_T2_LIM1 = 4'h0;
    localparam logic [3:0] GTP_T2_LIM4 = 4'h3;
    localparam logic [3:0] GTP_T2_LIM16 = 4'hF;

    // Quarter-rate instruction clock: last count of a 4-cycle divider.
    localparam logic [1:0] GTP_QDIV_LAST = 2'h3;

    // Single-pulse acquisition states.
    typedef enum logic [1:0] {GTP_SP_IDLE, GTP_SP_ARMED, GTP_SP_ACTIVE} gtp_sp_t;

    // Whole state of the block.
    typedef struct packed {
        logic [7:0] t1ctl;
        logic [7:0] t1gate;
        logic [7:0] t2ctl;
        logic [15:0] t1cnt;
        logic [7:0] t2cnt;
        logic [7:0] t2per;
        logic [2:0] t1pre;
        logic [3:0] t2pre;
        logic [3:0] t2post;
        logic [1:0] qdiv;
        logic [2:0] s_ext;
        logic [2:0] s_xtal;
        logic [2:0] s_cap;
        logic [2:0] s_gpin;
        logic [2:0] s_wdt;
        logic f_ext;
        logic f_xtal;
        logic f_cap;
        logic f_gpin;
        logic f_wdt;
        logic gsrc;
        logic tff;
        logic gated;
        gtp_sp_t sp;
        logic gval;
        logic fl_ovf;
        logic fl_t2;
        logic fl_gate;
        logic t2_match;
        logic [7:0] rdata;
    } gtp_state_t;

endpackage : gtp_pkg

// ===== logic/gtp_timer.sv
/*
 * Gated 16-bit timer with selectable prescaled clock and gate logic,
 * plus an 8-bit period timer with prescaler and postscaler.
 * Assumes one 50 MHz system clock, a synchronous reset, and a simple
 * register port whose read data appear the cycle after the read strobe.
 * Pins and foreign signals are sampled here; timer0 overflow is on mclk.
 */
// Functional notes
// - Clock source: cap osc, pin, sys, quarter
// - Source 10 uses pin or dedicated oscillator
// - Timer1 prescale divides by 8, 4, 2, 1
// - Sync-disable bit acts only for external sources
// - On bit enables; off clears gate flip-flop
// - Gate enable gates counting only while on
// - Polarity picks high or low active gate
// - Toggle flip-flop toggles, else held clear
// - Single-pulse mode takes over the gate
// - Go/done shows armed; cleared with mode
// - Gate level bit shows gate, read-only
// - Gate source: pin, t0, t2 match, wdt
// - Watchdog oscillator on when gated by it
// - Unimplemented control bits read zero
// - Period timer counts prescaled quarter clock
// - Period prescale 1, 4 or 16
// - Match with period resets count, advances postscaler
// - Postscale n flags every n+1 matches
// - Count, period read/write; reset 00h, FFh
// - Period timer runs only when on
// - Count or control write clears scalers
// - Single pulse: arm, count, clear on trailing
// - Falling gate level sets gate event flag
// - Counter rolls over, sets overflow flag
// - Period match gives pulse to gate logic
`timescale 1ns/1ps

module gtp_timer
    import gtp_pkg::*;
(
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst,
    // Register port.
    input wire logic [gtp_pkg::GTP_AW-1:0] addr,
    input wire logic [gtp_pkg::GTP_DW-1:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [gtp_pkg::GTP_DW-1:0] rdata,
    // Clock and gate inputs from outside.
    input wire logic t1_ext_clock_pin,
    input wire logic t1_xtal_osc,
    input wire logic cap_sense_osc,
    input wire logic t1_gate_pin,
    input wire logic wdt_scaler_ovf,
    input wire logic t0_overflow,
    // Status and side outputs.
    output logic wdt_osc_en,
    output logic t2_match_pulse,
    output logic t1_gate_level,
    output logic t1_overflow_flag,
    output logic t2_match_flag,
    output logic t1_gate_event_flag
);
    import gtp_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Helpers.

    // Accept a new level only once the second and third stages agree.
    function automatic logic filt(input logic [2:0] s, input logic prev);
        filt = (s[1] == s[2]) ? s[2] : prev;
    endfunction : filt

    // Rising edge, either filtered or straight from the sampling stages.
    function automatic logic rise(input logic [2:0] s, input logic fo,
                                  input logic fn, input logic nosync);
        rise = nosync ? (s[1] & ~s[2]) : (fn & ~fo);
    endfunction : rise

    localparam gtp_state_t ST_RST = '{
        t1ctl: GTP_T1CTL_RST,
        t1gate: GTP_T1GATE_RST,
        t2ctl: GTP_T2CTL_RST,
        t1cnt: GTP_T1CNT_RST,
        t2cnt: GTP_T2CNT_RST,
        t2per: GTP_T2PER_RST,
        sp: GTP_SP_IDLE,
        default: '0
    };

    gtp_state_t q;
    gtp_state_t d;

    ////////////////////////////////////////////////////////////////////
    // Decoded controls.

    logic t1_on;
    logic nosync;
    logic gate_en;
    logic gpol;
    logic gtm;
    logic spm;
    logic t2_on;
    logic [1:0] cs;
    logic [1:0] gss;
    logic [1:0] t1ps;
    logic [1:0] t2ps;
    logic [3:0] post_sel;

    // Field extraction from the control registers.
    assign t1_on = q.t1ctl[GTP_T1_ON];
    assign nosync = q.t1ctl[GTP_T1_NOSYNC];
    assign cs = q.t1ctl[GTP_T1_CS +: 2];
    assign t1ps = q.t1ctl[GTP_T1_PS +: 2];
    assign gate_en = q.t1gate[GTP_G_EN];
    assign gpol = q.t1gate[GTP_G_POL];
    assign gtm = q.t1gate[GTP_G_TM];
    assign spm = q.t1gate[GTP_G_SPM];
    assign gss = q.t1gate[GTP_G_SS +: 2];
    assign t2_on = q.t2ctl[GTP_T2_ON];
    assign t2ps = q.t2ctl[GTP_T2_PS +: 2];
    assign post_sel = q.t2ctl[GTP_T2_POST +: 4];

    // Outputs straight from state, apart from the oscillator request.
    assign rdata = q.rdata;
    assign t2_match_pulse = q.t2_match;
    assign t1_gate_level = q.gval;
    assign t1_overflow_flag = q.fl_ovf;
    assign t2_match_flag = q.fl_t2;
    assign t1_gate_event_flag = q.fl_gate;
    assign wdt_osc_en = gate_en & (gss == GTP_GS_WDT);

    ////////////////////////////////////////////////////////////////////
    // Next-state logic.

    always_comb
    begin
        logic qtick;
        logic t1tick;
        logic ext_r;
        logic xtal_r;
        logic cap_r;
        logic src;
        logic psrc;
        logic gated;
        logic cnt_en;
        logic [2:0] t1lim;
        logic [3:0] t2lim;
        logic t2tick;
        logic wr_t1lo;
        logic wr_t1hi;
        logic wr_t2cnt;
        logic wr_t2ctl;
        logic wr_gate;
        logic [7:0] clr;
        logic set_ovf;
        logic set_t2;
        logic set_gate;
        qtick = 1'b0;
        t1tick = 1'b0;
        ext_r = 1'b0;
        xtal_r = 1'b0;
        cap_r = 1'b0;
        src = 1'b0;
        psrc = 1'b0;
        gated = 1'b0;
        cnt_en = 1'b0;
        t1lim = 3'h0;
        t2lim = GTP_T2_LIM1;
        t2tick = 1'b0;
        set_ovf = 1'b0;
        set_t2 = 1'b0;
        set_gate = 1'b0;
        d = q;

        // Register strobes decoded once.
        wr_t1lo = wr_stb & (addr == GTP_A_T1LO);
        wr_t1hi = wr_stb & (addr == GTP_A_T1HI);
        wr_t2cnt = wr_stb & (addr == GTP_A_T2CNT);
        wr_t2ctl = wr_stb & (addr == GTP_A_T2CTL);
        wr_gate = wr_stb & (addr == GTP_A_T1GATE);
        clr = (wr_stb & (addr == GTP_A_FLAGS)) ? wdata : 8'h00;

        // Three-stage samplers; only the second stage reads the first.
        d.s_ext = {q.s_ext[1:0], t1_ext_clock_pin};
        d.s_xtal = {q.s_xtal[1:0], t1_xtal_osc};
        d.s_cap = {q.s_cap[1:0], cap_sense_osc};
        d.s_gpin = {q.s_gpin[1:0], t1_gate_pin};
        d.s_wdt = {q.s_wdt[1:0], wdt_scaler_ovf};
        d.f_ext = filt(q.s_ext, q.f_ext);
        d.f_xtal = filt(q.s_xtal, q.f_xtal);
        d.f_cap = filt(q.s_cap, q.f_cap);
        d.f_gpin = filt(q.s_gpin, q.f_gpin);
        d.f_wdt = filt(q.s_wdt, q.f_wdt);

        // Quarter-rate instruction clock enable.
        d.qdiv = q.qdiv + 2'h1;
        qtick = (q.qdiv == GTP_QDIV_LAST);

        // External edges; the sync-disable bit only matters for the pin, oscillator and cap sources.
        ext_r = rise(q.s_ext, q.f_ext, d.f_ext, nosync);
        xtal_r = rise(q.s_xtal, q.f_xtal, d.f_xtal, nosync);
        cap_r = rise(q.s_cap, q.f_cap, d.f_cap, nosync);

        // Timer1 clock source selection.
        case (cs)
            GTP_CS_QUARTER: t1tick = qtick;
            GTP_CS_SYS: t1tick = 1'b1;
            GTP_CS_EXT: t1tick = q.t1ctl[GTP_T1_OSCEN] ? xtal_r : ext_r;
            GTP_CS_CAP: t1tick = cap_r;
            default: t1tick = 1'b0;
        endcase

        // Gate source selection and polarity.
        case (gss)
            GTP_GS_PIN: src = q.f_gpin;
            GTP_GS_T0: src = t0_overflow;
            GTP_GS_T2: src = q.t2_match;
            GTP_GS_WDT: src = q.f_wdt;
            default: src = 1'b0;
        endcase
        psrc = gpol ? src : ~src;
        d.gsrc = psrc;

        // Toggle flip-flop, held clear when toggle mode or timer is off.
        if (!gtm || !t1_on)
        begin
            d.tff = 1'b0;
        end
        else if (psrc && !q.gsrc)
        begin
            d.tff = ~q.tff;
        end
        gated = gtm ? d.tff : psrc;
        d.gated = gated;

        // Single-pulse acquisition: armed by software, ended by trailing edge.
        case (q.sp)
            GTP_SP_ARMED:
            begin
                if (gated && !q.gated)
                begin
                    d.sp = GTP_SP_ACTIVE;
                end
            end
            GTP_SP_ACTIVE:
            begin
                if (!gated && q.gated)
                begin
                    d.sp = GTP_SP_IDLE;
                end
            end
            default: d.sp = GTP_SP_IDLE;
        endcase
        if (wr_gate)
        begin
            if (!wdata[GTP_G_GO])
            begin
                d.sp = GTP_SP_IDLE;
            end
            else if (q.sp == GTP_SP_IDLE)
            begin
                d.sp = GTP_SP_ARMED;
            end
        end
        // Leaving single-pulse mode always drops go/done.
        if (!(wr_gate ? wdata[GTP_G_SPM] : spm))
        begin
            d.sp = GTP_SP_IDLE;
        end

        // Gate level as seen by the counter, whatever the gate enable.
        if (spm)
        begin
            d.gval = gated & (d.sp == GTP_SP_ACTIVE);
        end
        else
        begin
            d.gval = gated;
        end
        set_gate = q.gval & ~d.gval;

        // Timer1 prescaler and counter.
        t1lim = 3'((4'h1 << t1ps) - 4'h1);
        cnt_en = !gate_en || q.gval;
        if (t1_on && t1tick)
        begin
            if (q.t1pre >= t1lim)
            begin
                d.t1pre = 3'h0;
                if (cnt_en)
                begin
                    d.t1cnt = q.t1cnt + 16'h0001;
                    set_ovf = (q.t1cnt == 16'hFFFF);
                end
            end
            else
            begin
                d.t1pre = q.t1pre + 3'h1;
            end
        end
        // Software writes beat a coincident increment.
        if (wr_t1lo)
        begin
            d.t1cnt[7:0] = wdata;
        end
        if (wr_t1hi)
        begin
            d.t1cnt[15:8] = wdata;
        end

        // Timer2 prescaler, match and postscaler.
        case (t2ps)
            2'h0: t2lim = GTP_T2_LIM1;
            2'h1: t2lim = GTP_T2_LIM4;
            default: t2lim = GTP_T2_LIM16;
        endcase
        d.t2_match = 1'b0;
        if (t2_on && qtick)
        begin
            if (q.t2pre >= t2lim)
            begin
                d.t2pre = 4'h0;
                t2tick = 1'b1;
            end
            else
            begin
                d.t2pre = q.t2pre + 4'h1;
            end
        end
        if (t2tick)
        begin
            if (q.t2cnt == q.t2per)
            begin
                d.t2cnt = 8'h00;
                d.t2_match = 1'b1;
                if (q.t2post == post_sel)
                begin
                    d.t2post = 4'h0;
                    set_t2 = 1'b1;
                end
                else
                begin
                    d.t2post = q.t2post + 4'h1;
                end
            end
            else
            begin
                d.t2cnt = q.t2cnt + 8'h01;
            end
        end
        // Count or control writes restart both scalers.
        if (wr_t2cnt || wr_t2ctl)
        begin
            d.t2pre = 4'h0;
            d.t2post = 4'h0;
        end
        if (wr_t2cnt)
        begin
            d.t2cnt = wdata;
        end

        // Control and period register writes.
        if (wr_stb)
        begin
            case (addr)
                GTP_A_T1CTL: d.t1ctl = wdata & GTP_T1CTL_MASK;
                GTP_A_T1GATE: d.t1gate = wdata & GTP_T1GATE_MASK;
                GTP_A_T2CTL: d.t2ctl = wdata & GTP_T2CTL_MASK;
                GTP_A_T2PER: d.t2per = wdata;
                default: d.t1ctl = q.t1ctl;
            endcase
        end

        // Sticky flags: a set in the same cycle as a clear wins.
        d.fl_ovf = (q.fl_ovf & ~clr[GTP_F_OVF]) | set_ovf;
        d.fl_t2 = (q.fl_t2 & ~clr[GTP_F_T2]) | set_t2;
        d.fl_gate = (q.fl_gate & ~clr[GTP_F_GATE]) | set_gate;

        // Read data stand only in the cycle after the read strobe.
        d.rdata = 8'h00;
        if (rd_stb)
        begin
            case (addr)
                GTP_A_T1CTL: d.rdata = q.t1ctl & GTP_T1CTL_MASK;
                GTP_A_T1GATE: d.rdata = {q.t1gate[7:4], q.sp != GTP_SP_IDLE,
                                         q.gval, q.t1gate[1:0]};
                GTP_A_T1LO: d.rdata = q.t1cnt[7:0];
                GTP_A_T1HI: d.rdata = q.t1cnt[15:8];
                GTP_A_T2CNT: d.rdata = q.t2cnt;
                GTP_A_T2PER: d.rdata = q.t2per;
                GTP_A_T2CTL: d.rdata = q.t2ctl & GTP_T2CTL_MASK;
                GTP_A_FLAGS: d.rdata = {q.fl_gate, 5'h00, q.fl_t2, q.fl_ovf};
                default: d.rdata = 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // State register; reset clears scalers and loads count/period.

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            q <= ST_RST;
        end
        else
        begin
            q <= d;
        end
    end

endmodule : gtp_timer

// ===== tb/gtp_timer_chk.sv
/*
 * Checker for the gated timer block, bound to its top module.
 * Assumes a single clock domain and a synchronous active-high reset.
 */
`timescale 1ns/1ps

module gtp_timer_chk
    import gtp_pkg::*;
(
    // Clock, reset and register port.
    input wire logic mclk,
    input wire logic rst,
    input wire logic [gtp_pkg::GTP_AW-1:0] addr,
    input wire logic [gtp_pkg::GTP_DW-1:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic [gtp_pkg::GTP_DW-1:0] rdata,
    // Side outputs.
    input wire logic wdt_osc_en,
    input wire logic t2_match_pulse,
    input wire logic t1_gate_level,
    input wire logic t1_overflow_flag,
    input wire logic t2_match_flag,
    input wire logic t1_gate_event_flag
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    logic [7:0] t1c_q;
    logic [7:0] t2c_q;
    logic [7:0] gc_q;
    logic [2:0] age_q;

    ////////////////////////////////////////
    // Shadow copies of control writes, so the mode is known without looking inside.
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            t1c_q <= 8'h00;
            t2c_q <= 8'h00;
            gc_q <= 8'h00;
            age_q <= 3'h7;
        end
        else
        begin
            if (wr_stb && addr == GTP_A_T1CTL)
                t1c_q <= wdata;
            if (wr_stb && addr == GTP_A_T2CTL)
                t2c_q <= wdata;
            if (wr_stb && addr == GTP_A_T1GATE)
                gc_q <= wdata;
            age_q <= t2_match_pulse ? 3'h0 : ((age_q == 3'h7) ? age_q : age_q + 3'h1);
        end
    end

    ////////////////////////////////////////
    // Single-pulse mode dropped, then the gate register read back.
    sequence s_spm_off;
        wr_stb && addr == GTP_A_T1GATE && !wdata[GTP_G_SPM];
    endsequence
    sequence s_gate_rd;
        rd_stb && addr == GTP_A_T1GATE;
    endsequence

    property p_rst_quiet;
        @(posedge mclk) disable iff (1'b0) rst |=> rdata == 8'h00 && !t2_match_pulse;
    endproperty
    property p_t1_rsv;
        rd_stb && addr == GTP_A_T1CTL |=> !rdata[1];
    endproperty
    property p_t2_rsv;
        rd_stb && addr == GTP_A_T2CTL |=> !rdata[7];
    endproperty
    property p_wdt_osc;
        wdt_osc_en == (gc_q[GTP_G_EN] && gc_q[1:0] == GTP_GS_WDT);
    endproperty
    property p_gval_rd;
        s_gate_rd |=> rdata[GTP_G_VAL] == $past(t1_gate_level);
    endproperty
    property p_gate_evt;
        $fell(t1_gate_level) |-> ##[0:2] t1_gate_event_flag;
    endproperty
    property p_ovf_sticky;
        t1_overflow_flag && !(wr_stb && addr == GTP_A_FLAGS && wdata[GTP_F_OVF])
            |=> t1_overflow_flag;
    endproperty
    property p_t2_sticky;
        t2_match_flag && !(wr_stb && addr == GTP_A_FLAGS && wdata[GTP_F_T2])
            |=> t2_match_flag;
    endproperty
    property p_t2_off;
        !t2c_q[GTP_T2_ON] [*3] |-> !t2_match_pulse;
    endproperty
    property p_t1_off;
        !t1c_q[GTP_T1_ON] [*4] |-> !$rose(t1_overflow_flag);
    endproperty
    property p_flag_src;
        $rose(t2_match_flag) |-> (t2_match_pulse || age_q < 3'h2) or (##1 t2_match_pulse);
    endproperty
    property p_spm_go;
        s_spm_off ##[1:2] s_gate_rd |=> !rdata[GTP_G_GO];
    endproperty

    a_rst_quiet: assert property (p_rst_quiet)
        else $error("outputs not quiet after reset");
    a_t1_rsv: assert property (p_t1_rsv)
        else $error("timer1 control bit 1 read as one");
    a_t2_rsv: assert property (p_t2_rsv)
        else $error("timer2 control bit 7 read as one");
    a_wdt_osc: assert property (p_wdt_osc)
        else $error("watchdog oscillator request wrong");
    a_gval_rd: assert property (p_gval_rd)
        else $error("gate level bit differs from gate level");
    a_gate_evt: assert property (p_gate_evt)
        else $error("gate level fell without event flag");
    a_ovf_sticky: assert property (p_ovf_sticky)
        else $error("overflow flag dropped without clear");
    a_t2_sticky: assert property (p_t2_sticky)
        else $error("timer2 flag dropped without clear");
    a_t2_off: assert property (p_t2_off)
        else $error("timer2 matched while off");
    a_t1_off: assert property (p_t1_off)
        else $error("timer1 overflowed while off");
    a_flag_src: assert property (p_flag_src)
        else $error("timer2 flag set away from a match");
    a_spm_go: assert property (p_spm_go)
        else $error("go bit survived single-pulse mode off");

endmodule : gtp_timer_chk

bind gtp_timer gtp_timer_chk chk_u (
    .mclk(mclk),
    .rst(rst),
    .addr(addr),
    .wdata(wdata),
    .wr_stb(wr_stb),
    .rd_stb(rd_stb),
    .rdata(rdata),
    .wdt_osc_en(wdt_osc_en),
    .t2_match_pulse(t2_match_pulse),
    .t1_gate_level(t1_gate_level),
    .t1_overflow_flag(t1_overflow_flag),
    .t2_match_flag(t2_match_flag),
    .t1_gate_event_flag(t1_gate_event_flag)
);

// ===== tb/gtp_timer_tb.sv
/*
 * Self-checking bench for the gated timer block.
 * Assumes the register map of the shared package and a 50 MHz clock.
 */
`timescale 1ns/1ps

module gtp_timer_tb;
    import gtp_pkg::*;

    typedef struct packed {logic w; logic [2:0] a; logic [7:0] d; logic [7:0] e;} gtp_reg_row_t;
    typedef struct packed {logic [7:0] t1; logic [7:0] g; logic lvl; logic [7:0] e;} gtp_cnt_row_t;

    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic gsig = 1'b0;
    logic [3:0] cyc = 4'h0;
    logic [7:0] rdata;
    logic wdt_osc_en;
    logic t2_match_pulse;
    logic t1_gate_level;
    logic t1_overflow_flag;
    logic t2_match_flag;
    logic t1_gate_event_flag;
    int mismatches = 0;
    int tests_run = 0;
    gtp_reg_row_t reg_rows[18] = '{
        '{0, 0, 0, 0}, '{0, 1, 0, 8'h04}, '{0, 2, 0, 0}, '{0, 3, 0, 0}, '{0, 4, 0, 0},
        '{0, 5, 0, 8'hFF}, '{0, 6, 0, 0}, '{0, 7, 0, 0}, '{1, 0, 8'hFF, 8'hFD},
        '{1, 0, 0, 0}, '{1, 6, 8'hFF, 8'h7F}, '{1, 6, 0, 0}, '{1, 5, 8'h5A, 8'h5A},
        '{1, 4, 8'hA5, 8'hA5}, '{1, 2, 8'h34, 8'h34}, '{1, 3, 8'h12, 8'h12},
        '{1, 1, 8'hF3, 8'hF3}, '{1, 1, 0, 8'h04}};
    gtp_cnt_row_t cnt_rows[19] = '{
        '{8'h01, 0, 0, 8'h10}, '{8'h11, 0, 0, 8'h08}, '{8'h21, 0, 0, 8'h04},
        '{8'h31, 0, 0, 8'h02}, '{8'h41, 0, 0, 8'h40}, '{8'h51, 0, 0, 8'h20},
        '{8'h61, 0, 0, 8'h10}, '{8'h71, 0, 0, 8'h08}, '{8'h81, 0, 0, 8'h08},
        '{8'h85, 0, 0, 8'h08}, '{8'h89, 0, 0, 8'h10}, '{8'hC1, 0, 0, 8'h04},
        '{8'h41, 8'hC0, 0, 8'h00}, '{8'h41, 8'hC0, 1, 8'h40}, '{8'h41, 8'h80, 0, 8'h40},
        '{8'h41, 8'hC1, 1, 8'h40}, '{8'h41, 8'hC3, 0, 8'h00}, '{8'h41, 8'h82, 0, 8'h40},
        '{8'h41, 8'h40, 0, 8'h40}};
    logic [7:0] t2_ctl[5] = '{8'h04, 8'h0D, 8'h06, 8'h7C, 8'h17};
    int t2_cyc[5] = '{16, 128, 256, 256, 768};
    logic [7:0] tgl_exp[3] = '{8'hE4, 8'hE0, 8'hE4};

    ////////////////////////////////////////
    // Clock, and free-running source clocks of three rates.
    always #10 mclk = ~mclk;
    always @(posedge mclk)
        cyc <= cyc + 4'h1;

    gtp_timer dut_u (
        .mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .rdata(rdata), .t1_ext_clock_pin(cyc[2]), .t1_xtal_osc(cyc[1]),
        .cap_sense_osc(cyc[3]), .t1_gate_pin(gsig), .wdt_scaler_ovf(gsig),
        .t0_overflow(gsig), .wdt_osc_en(wdt_osc_en), .t2_match_pulse(t2_match_pulse),
        .t1_gate_level(t1_gate_level), .t1_overflow_flag(t1_overflow_flag),
        .t2_match_flag(t2_match_flag), .t1_gate_event_flag(t1_gate_event_flag));

    ////////////////////////////////////////
    // Bus tasks; each leaves an idle edge so no strobe is set twice in one step.
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge mclk);
        wr_stb <= 1'b0;
    endtask : wr

    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge mclk);
        rd_stb <= 1'b0;
        #1;
        d = rdata;
    endtask : rd

    // Counts derived from asynchronous sources are allowed a small tolerance.
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g, input int tol);
        tests_run++;
        if ((^g === 1'bx) || (g + tol < e) || (g > e + tol))
        begin
            mismatches++;
            $display("[FAIL] %s expected %0h seen %0h", n, e, g);
        end
    endtask : chk

    task automatic pulse(input int n);
        @(posedge mclk);
        gsig <= 1'b1;
        repeat (n) @(posedge mclk);
        gsig <= 1'b0;
        repeat (10) @(posedge mclk);
    endtask : pulse

    task automatic end_sim;
        $display("Checks %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_sim

    ////////////////////////////////////////
    // Main sequence: table cases, then the awkward ones.
    initial
    begin
        logic [7:0] d;
        int n;
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        foreach (reg_rows[i])
        begin
            if (reg_rows[i].w)
                wr(reg_rows[i].a, reg_rows[i].d);
            rd(reg_rows[i].a, d);
            chk($sformatf("reg_row%0d", i), reg_rows[i].e, d, 0);
        end
        foreach (cnt_rows[i])
        begin
            gsig <= cnt_rows[i].lvl;
            wr(GTP_A_T1GATE, cnt_rows[i].g);
            wr(GTP_A_T1LO, 8'h00);
            wr(GTP_A_T1HI, 8'h00);
            wr(GTP_A_T1CTL, cnt_rows[i].t1);
            repeat (62) @(posedge mclk);
            wr(GTP_A_T1CTL, cnt_rows[i].t1 & 8'hFE);
            rd(GTP_A_T1LO, d);
            chk($sformatf("count_row%0d", i), cnt_rows[i].e, d, 1);
        end
        // Rollover from the top of the 16-bit range.
        gsig <= 1'b0;
        wr(GTP_A_T1GATE, 8'h00);
        wr(GTP_A_T1HI, 8'hFF);
        wr(GTP_A_T1LO, 8'hF0);
        wr(GTP_A_T1CTL, 8'h41);
        repeat (30) @(posedge mclk);
        wr(GTP_A_T1CTL, 8'h40);
        chk("ovf_flag", 1, t1_overflow_flag, 0);
        rd(GTP_A_T1HI, d);
        chk("count_hi", 8'h00, d, 0);
        wr(GTP_A_FLAGS, 8'h01);
        #1;
        chk("ovf_clear", 0, t1_overflow_flag, 0);
        // Timer2 flag spacing over prescale and postscale settings, period 3.
        wr(GTP_A_T2PER, 8'h03);
        foreach (t2_ctl[i])
        begin
            wr(GTP_A_FLAGS, 8'h02);
            wr(GTP_A_T2CNT, 8'h00);
            wr(GTP_A_T2CTL, t2_ctl[i]);
            n = 0;
            while (t2_match_flag !== 1'b1 && n < 5000)
            begin
                @(posedge mclk);
                #1;
                n++;
            end
            if (n >= 5000)
            begin
                mismatches++;
                end_sim();
            end
            chk($sformatf("t2_row%0d", i), t2_cyc[i], n, 8);
            wr(GTP_A_T2CTL, 8'h00);
        end
        wr(GTP_A_T2CNT, 8'h37);
        wr(GTP_A_T2CTL, 8'h08);
        rd(GTP_A_T2CNT, d);
        chk("t2_keep", 8'h37, d, 0);
        // Single-pulse acquisition: one pulse counted, the next ignored.
        wr(GTP_A_T1CTL, 8'h41);
        wr(GTP_A_T1GATE, 8'hD0);
        wr(GTP_A_FLAGS, 8'h80);
        wr(GTP_A_T1GATE, 8'hD8);
        wr(GTP_A_T1LO, 8'h00);
        rd(GTP_A_T1GATE, d);
        chk("armed", 8'hD8, d, 0);
        pulse(12);
        rd(GTP_A_T1GATE, d);
        chk("done", 8'hD0, d, 0);
        chk("gate_evt", 1, t1_gate_event_flag, 0);
        rd(GTP_A_T1LO, d);
        chk("sp_count", 12, d, 2);
        pulse(12);
        rd(GTP_A_T1LO, d);
        chk("sp_hold", 12, d, 2);
        wr(GTP_A_T1GATE, 8'hC8);
        rd(GTP_A_T1GATE, d);
        chk("go_cleared", 8'hC0, d, 0);
        // Toggle mode, then switching the timer off clears the flip-flop.
        wr(GTP_A_T1GATE, 8'hE0);
        foreach (tgl_exp[i])
        begin
            pulse(4);
            rd(GTP_A_T1GATE, d);
            chk("toggle", tgl_exp[i], d, 0);
        end
        wr(GTP_A_T1CTL, 8'h40);
        rd(GTP_A_T1GATE, d);
        chk("off_clears_ff", 8'hE0, d, 0);
        end_sim();
    end

endmodule : gtp_timer_tb
